// *** rsqr_cfg.svh ***
// Purpose: constants for the runtime status query responder
// Assumes: byte offsets on a 32-bit AHB-Lite slave
// Notes:   field ranges are used as vector[`NAME]
`ifndef RSQR_CFG_SVH
`define RSQR_CFG_SVH
`define RSQR_OFF_QUERY   8'h00
`define RSQR_OFF_REPLY   8'h04
`define RSQR_OFF_REPLYHI 8'h08
`define RSQR_OFF_RSTAT   8'h0C
`define RSQR_OFF_CTRL    8'h10
`define RSQR_OFF_FLAGS   8'h14
`define RSQR_OFF_HALL    8'h18
`define RSQR_Q_CODE      7:0
`define RSQR_Q_ARG       15:8
`define RSQR_Q_INDEX     31:16
`define RSQR_CTRL_HALL120 0
`define RSQR_CTRL_RADIO   1
`define RSQR_CODE_FLAGS  8'h14
`define RSQR_CODE_HALL   8'h31
`define RSQR_CODE_NODE   8'h46
`define RSQR_CODE_RADIO  8'h21
`define RSQR_CODE_LOCK   8'h1D
`define RSQR_CODE_CMD    8'h01
`define RSQR_CODE_AMPS   8'h25
`define RSQR_CODE_TAPE   8'h29
`define RSQR_CODE_MARK   8'h2B
`define RSQR_IDX_FLAGS   16'h2111
`define RSQR_IDX_HALL    16'h2123
`define RSQR_IDX_RADIO   16'h211A
`define RSQR_IDX_CMD     16'h2101
`define RSQR_IDX_AMPS    16'h211C
`define RSQR_IDX_TAPE    16'h211D
`define RSQR_IDX_MARK    16'h211F
`define RSQR_MOTORS      2
`define RSQR_PULSE_IN    2
`define RSQR_RADIO_CH    6
`define RSQR_RADIO_W     11
`define RSQR_NODE_MAX    127
`define RSQR_HALL_RST    6'h3F
`endif

// *** rsqr_host.sv ***
// Purpose: AHB-Lite host issuing single word transfers to the responder
// Assumes: one slave, its hreadyout is the bus hready
// Notes:   tasks are entered just after a rising edge and leave on one
module rsqr_host (
   input  wire logic        hclk,
   input  wire logic        hready,
   input  wire logic [31:0] hrdata,
   output logic             hsel,
   output logic [31:0]      haddr,
   output logic [1:0]       htrans,
   output logic             hwrite,
   output logic [2:0]       hsize,
   output logic [31:0]      hwdata
);
   timeunit 1ns;
   timeprecision 100ps;

   // Bus quiet until the first transfer
   initial
   begin
      hsel   = 1'b0;
      haddr  = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize  = 3'h2;
      hwdata = 32'h0;
   end

   // Address phase held until hready, then data phase held until hready
   task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= a;
      hwrite <= w;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata; // Read data taken at the closing edge
   endtask
endmodule // rsqr_host

// *** rsqr_pkg.sv ***
// Purpose: types for the runtime status query responder
// Assumes: nothing
// Notes:   query kinds after code or object index decode
package rsqr_pkg;
   typedef enum logic [3:0] {K_NONE, K_FLAGS, K_HALL, K_NODE, K_RADIO, K_LOCK,
                             K_CMD, K_AMPS, K_TAPE, K_MARK} rsqr_kind_t;
   typedef enum logic {ST_IDLE, ST_EVAL} rsqr_state_t;
endpackage

// *** rsqr_top.sv ***
// Purpose: answers runtime status queries over AHB-Lite
// Assumes: one clock, hresetn async active low, 2 motors, 2 pulse inputs
// Notes:   a write to QUERY is answered one cycle after it lands
//
// Design decisions made here: the AHB-Lite slave port and the register addresses.
`include "rsqr_cfg.svh"
module rsqr_top (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        serial_mode,
   input  wire logic        pulse_mode,
   input  wire logic        analog_mode,
   input  wire logic        radio_mode,
   input  wire logic        power_off,
   input  wire logic        stall_det,
   input  wire logic        at_limit,
   input  wire logic        script_run,
   input  wire logic        tuning_mode,
   input  wire logic [1:0]  hall_input_a,
   input  wire logic [1:0]  hall_input_b,
   input  wire logic [1:0]  hall_input_c,
   input  wire logic [127:0] node_alive,
   input  wire logic [65:0] radio_raw,
   input  wire logic        radio_link_ok,
   input  wire logic        config_locked,
   input  wire logic [63:0] applied_cmd,
   input  wire logic [63:0] vec_current,
   input  wire logic        multi_sensor,
   input  wire logic [1:0]  tape_det,
   input  wire logic [3:0]  tape_mark
);
   import rsqr_pkg::*;

   // Code or field-bus index both select a query kind
   function automatic rsqr_kind_t decode_kind(input logic [7:0] code, input logic [15:0] idx);
      rsqr_kind_t k;
      k = K_NONE;
      case (code)
         `RSQR_CODE_FLAGS: k = K_FLAGS;
         `RSQR_CODE_HALL:  k = K_HALL;
         `RSQR_CODE_NODE:  k = K_NODE;
         `RSQR_CODE_RADIO: k = K_RADIO;
         `RSQR_CODE_LOCK:  k = K_LOCK;
         `RSQR_CODE_CMD:   k = K_CMD;
         `RSQR_CODE_AMPS:  k = K_AMPS;
         `RSQR_CODE_TAPE:  k = K_TAPE;
         `RSQR_CODE_MARK:  k = K_MARK;
         8'h00:
         begin
            case (idx)
               `RSQR_IDX_FLAGS: k = K_FLAGS;
               `RSQR_IDX_HALL:  k = K_HALL;
               `RSQR_IDX_RADIO: k = K_RADIO;
               `RSQR_IDX_CMD:   k = K_CMD;
               `RSQR_IDX_AMPS:  k = K_AMPS;
               `RSQR_IDX_TAPE:  k = K_TAPE;
               `RSQR_IDX_MARK:  k = K_MARK;
               default:         k = K_NONE;
            endcase
         end
         default: k = K_NONE;
      endcase
      return k;
   endfunction

   // Valid hall combinations depend on sensor spacing
   function automatic logic hall_valid(input logic [2:0] c, input logic sp120);
      return sp120 ? (c != 3'h0 && c != 3'h7) : (c != 3'h2 && c != 3'h5);
   endfunction

   logic        wr_ff;
   logic [7:0]  addr_ff;
   logic [31:0] hrdata_ff;
   logic        hreadyout_ff;
   logic        hresp_ff;
   logic [31:0] query_ff;
   logic [1:0]  ctrl_ff;
   logic [63:0] reply_ff;
   logic [63:0] nxt_reply;
   logic        rej_ff;
   logic        nxt_rej;
   logic        done_ff;
   rsqr_state_t st_ff;
   logic [5:0]  h_meta_ff;
   logic [5:0]  h_sync_ff;
   logic [2:0]  hall_code [2];
   logic [1:0]  hall_ok;
   logic [15:0] flags;
   logic [31:0] rd_mux;
   rsqr_kind_t  kind;
   logic [7:0]  arg;
   logic        acc;

   assign hrdata    = hrdata_ff;
   assign hreadyout = hreadyout_ff;
   assign hresp     = hresp_ff;
   assign acc       = hsel & hready & htrans[1];
   assign kind      = decode_kind(query_ff[`RSQR_Q_CODE], query_ff[`RSQR_Q_INDEX]);
   assign arg       = query_ff[`RSQR_Q_ARG];

   // Hall pins are asynchronous; reset to high so an open input reads 7
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         h_meta_ff <= `RSQR_HALL_RST;
         h_sync_ff <= `RSQR_HALL_RST;
      end
      else
      begin
         h_meta_ff <= {hall_input_c, hall_input_b, hall_input_a};
         h_sync_ff <= h_meta_ff;
      end
   end

   // Per-channel hall code and its validity
   for (genvar g = 0; g < `RSQR_MOTORS; g++)
   begin : g_hall
      assign hall_code[g] = {h_sync_ff[4+g], h_sync_ff[2+g], h_sync_ff[g]};
      assign hall_ok[g]   = hall_valid(hall_code[g], ctrl_ff[`RSQR_CTRL_HALL120]);
   end

   // Status word; radio variant shifts the power-stage group up one bit
   always_comb
   begin
      flags = 16'h0000;
      flags[0] = serial_mode;
      flags[1] = pulse_mode;
      flags[2] = analog_mode;
      if (ctrl_ff[`RSQR_CTRL_RADIO])
      begin
         flags[3] = radio_mode;
         flags[4] = power_off;
         flags[5] = stall_det;
         flags[6] = at_limit;
      end
      else
      begin
         flags[3] = power_off;
         flags[4] = stall_det;
         flags[5] = at_limit;
         flags[6] = 1'b0;
      end
      flags[7] = script_run;
      flags[8] = tuning_mode;
   end

   // Register read mux; config reads blank while locked
   always_comb
   begin
      case (haddr[7:0])
         `RSQR_OFF_QUERY:   rd_mux = query_ff;
         `RSQR_OFF_REPLY:   rd_mux = reply_ff[31:0];
         `RSQR_OFF_REPLYHI: rd_mux = reply_ff[63:32];
         `RSQR_OFF_RSTAT:   rd_mux = {query_ff[`RSQR_Q_INDEX], query_ff[`RSQR_Q_CODE], 5'h00,
                                      config_locked, rej_ff, done_ff};
         `RSQR_OFF_CTRL:    rd_mux = config_locked ? 32'h0 : {30'h0, ctrl_ff};
         `RSQR_OFF_FLAGS:   rd_mux = {16'h0, flags};
         `RSQR_OFF_HALL:    rd_mux = {22'h0, hall_ok, 1'b0, hall_code[1], 1'b0, hall_code[0]};
         default:           rd_mux = 32'h0;
      endcase
   end

   // AHB-Lite: zero wait states, read data registered at address phase
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_ff        <= 1'b0;
         addr_ff      <= 8'h00;
         hrdata_ff    <= 32'h0;
         hreadyout_ff <= 1'b0;
         hresp_ff     <= 1'b0;
      end
      else
      begin
         wr_ff        <= acc & hwrite;
         addr_ff      <= haddr[7:0];
         hrdata_ff    <= (acc & ~hwrite) ? rd_mux : 32'h0;
         hreadyout_ff <= 1'b1;
         hresp_ff     <= 1'b0;
      end
   end

   // Control register steers hall spacing and flag layout
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         ctrl_ff <= 2'h0;
      else if (wr_ff && addr_ff == `RSQR_OFF_CTRL)
         ctrl_ff <= hwdata[1:0];
   end

   // Query capture and evaluation sequence
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         query_ff <= 32'h0;
         st_ff    <= ST_IDLE;
         done_ff  <= 1'b0;
         rej_ff   <= 1'b0;
         reply_ff <= 64'h0;
      end
      else if (wr_ff && addr_ff == `RSQR_OFF_QUERY)
      begin
         query_ff <= hwdata;
         st_ff    <= ST_EVAL;
         done_ff  <= 1'b0;
      end
      else
      begin
         case (st_ff)
            ST_EVAL:
            begin
               reply_ff <= nxt_reply;
               rej_ff   <= nxt_rej;
               done_ff  <= 1'b1;
               st_ff    <= ST_IDLE;
            end
            default: st_ff <= ST_IDLE;
         endcase
      end
   end

   // Answer for the captured query; rejects answer zero
   always_comb
   begin
      nxt_reply = 64'h0;
      nxt_rej   = 1'b0;
      case (kind)
         K_FLAGS: nxt_reply[15:0] = flags;
         K_HALL:
         begin
            if (arg == 8'h00)
               nxt_reply[15:0] = {5'h00, hall_code[1], 5'h00, hall_code[0]};
            else if (arg <= 8'(`RSQR_MOTORS))
               nxt_reply[2:0] = hall_code[arg[0] ? 0 : 1];
            else
               nxt_rej = 1'b1;
         end
         K_NODE:
         begin
            if (arg != 8'h00 && arg <= 8'(`RSQR_NODE_MAX))
               nxt_reply[0] = node_alive[arg[6:0]];
            else
               nxt_rej = 1'b1;
         end
         K_RADIO:
         begin
            if (arg != 8'h00 && arg <= 8'(`RSQR_RADIO_CH))
               nxt_reply[10:0] = radio_link_ok ? radio_raw[7'(arg - 8'h01) * 7'd11 +: 11] : 11'h0;
            else
               nxt_rej = 1'b1;
         end
         K_LOCK: nxt_reply[0] = config_locked;
         K_CMD:
         begin
            if (arg == 8'h00)
               nxt_reply = applied_cmd;
            else if (arg <= 8'(`RSQR_MOTORS))
               nxt_reply[31:0] = applied_cmd[(arg[0] ? 0 : 32) +: 32];
            else
               nxt_rej = 1'b1;
         end
         K_AMPS:
         begin
            if (arg != 8'h00 && arg <= 8'(2 * `RSQR_MOTORS))
               nxt_reply = 64'(signed'(vec_current[6'(arg - 8'h01) * 6'd16 +: 16]));
            else
               nxt_rej = 1'b1;
         end
         K_TAPE:
         begin
            if (!multi_sensor && arg <= 8'h01)
               nxt_reply[0] = |tape_det;
            else if (multi_sensor && arg == 8'h00)
               nxt_reply[15:0] = {7'h00, tape_det[1], 7'h00, tape_det[0]};
            else if (multi_sensor && arg <= 8'(`RSQR_PULSE_IN))
               nxt_reply[0] = tape_det[arg[0] ? 0 : 1];
            else
               nxt_rej = 1'b1;
         end
         K_MARK:
         begin
            if (!multi_sensor && (arg == 8'h01 || arg == 8'h02))
               nxt_reply[0] = arg[0] ? (tape_mark[0] | tape_mark[2]) : (tape_mark[1] | tape_mark[3]);
            else if (multi_sensor && arg != 8'h00 && arg <= 8'(2 * `RSQR_PULSE_IN))
               nxt_reply[0] = tape_mark[2'(arg - 8'h01)];
            else
               nxt_rej = 1'b1;
         end
         default: nxt_rej = 1'b1;
      endcase
   end

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   property p_flags_word;
      st_ff == ST_EVAL && kind == K_FLAGS |=> done_ff && !rej_ff && reply_ff[63:16] == 48'h0;
   endproperty
   a_flags_word: assert property (p_flags_word) else $error("status word too wide");

   property p_flags_norm;
      st_ff == ST_EVAL && kind == K_FLAGS && !ctrl_ff[1]
         |=> reply_ff[0] == $past(serial_mode) && reply_ff[3] == $past(power_off) && reply_ff[5] == $past(at_limit);
   endproperty
   a_flags_norm: assert property (p_flags_norm) else $error("status bit layout wrong");

   property p_flags_upper;
      st_ff == ST_EVAL && kind == K_FLAGS && !ctrl_ff[1]
         |=> !reply_ff[6] && reply_ff[7] == $past(script_run) && reply_ff[8] == $past(tuning_mode);
   endproperty
   a_flags_upper: assert property (p_flags_upper) else $error("upper status bits wrong");

   property p_flags_radio;
      st_ff == ST_EVAL && kind == K_FLAGS && ctrl_ff[1]
         |=> reply_ff[3] == $past(radio_mode) && reply_ff[6] == $past(at_limit);
   endproperty
   a_flags_radio: assert property (p_flags_radio) else $error("radio shift wrong");

   property p_hall_range;
      st_ff == ST_EVAL && kind == K_HALL && arg == 8'h01 |=> reply_ff[63:3] == 61'h0 && !rej_ff;
   endproperty
   a_hall_range: assert property (p_hall_range) else $error("hall value out of range");

   property p_hall_open;
      (&hall_input_a[0] && hall_input_b[0] && hall_input_c[0])[*2] |=> hall_code[0] == 3'h7;
   endproperty
   a_hall_open: assert property (p_hall_open) else $error("open hall not 7");

   property p_hall_60;
      acc && !hwrite && haddr[7:0] == `RSQR_OFF_HALL && !ctrl_ff[0] && hall_code[0] == 3'h2 |=> !hrdata_ff[8];
   endproperty
   a_hall_60: assert property (p_hall_60) else $error("code 2 valid at 60");

   property p_hall_120;
      acc && !hwrite && haddr[7:0] == `RSQR_OFF_HALL && ctrl_ff[0] && hall_code[0] == 3'h7 |=> !hrdata_ff[8];
   endproperty
   a_hall_120: assert property (p_hall_120) else $error("code 7 valid at 120");

   property p_node_zero;
      st_ff == ST_EVAL && kind == K_NODE && arg == 8'h00 |=> rej_ff && reply_ff == 64'h0;
   endproperty
   a_node_zero: assert property (p_node_zero) else $error("node 0 accepted");

   property p_radio_off;
      st_ff == ST_EVAL && kind == K_RADIO && !radio_link_ok |=> reply_ff == 64'h0;
   endproperty
   a_radio_off: assert property (p_radio_off) else $error("radio value without link");

   property p_lock_read;
      acc && !hwrite && haddr[7:0] == `RSQR_OFF_CTRL && config_locked |=> hrdata_ff == 32'h0;
   endproperty
   a_lock_read: assert property (p_lock_read) else $error("config read while locked");

   property p_cmd_ch1;
      st_ff == ST_EVAL && kind == K_CMD && arg == 8'h01 |=> reply_ff[31:0] == $past(applied_cmd[31:0]);
   endproperty
   a_cmd_ch1: assert property (p_cmd_ch1) else $error("applied command wrong");

   property p_amps_torque;
      st_ff == ST_EVAL && kind == K_AMPS && arg == 8'h02 |=> reply_ff[15:0] == $past(vec_current[31:16]);
   endproperty
   a_amps_torque: assert property (p_amps_torque) else $error("torque index wrong");

   property p_query_turn;
      wr_ff && addr_ff == `RSQR_OFF_QUERY |=> st_ff == ST_EVAL && !done_ff ##1 done_ff;
   endproperty
   a_query_turn: assert property (p_query_turn) else $error("query not answered in one cycle");

   c_flags: cover property (st_ff == ST_EVAL && query_ff[`RSQR_Q_CODE] == `RSQR_CODE_FLAGS);
   c_hall_idx: cover property (st_ff == ST_EVAL && query_ff[`RSQR_Q_INDEX] == `RSQR_IDX_HALL);
   c_reject: cover property (st_ff == ST_EVAL ##1 rej_ff);
   c_mark_multi: cover property (st_ff == ST_EVAL && kind == K_MARK && multi_sensor);
endmodule // rsqr_top

// *** tb_runtime_status_query_responder.sv ***
// Purpose: self-checking bench for the runtime status query responder
// Assumes: two motors, two pulse inputs, zero wait-state slave
// Notes:   expected replies come from a behavioural model of the queries
`include "rsqr_cfg.svh"
module tb_runtime_status_query_responder;
   timeunit 1ns;
   timeprecision 100ps;
   logic         hclk = 1'b0;
   logic         hresetn;
   logic         hsel, hwrite, hreadyout, hresp;
   logic [1:0]   htrans, hall_a, hall_b, hall_c, det, ctrl;
   logic [2:0]   hsize;
   logic [31:0]  haddr, hwdata, hrdata, d, rnd;
   logic [8:0]   st;
   logic [127:0] node;
   logic [65:0]  raw;
   logic         link, lock, multi;
   logic [63:0]  cmd, amps;
   logic [3:0]   mark;
   int           failures = 0;
   int           total_checks = 0;
   integer       seed = 32'h1488A2C1;
   logic [7:0]   codes [9] = '{`RSQR_CODE_FLAGS, `RSQR_CODE_HALL, `RSQR_CODE_NODE, `RSQR_CODE_RADIO,
                               `RSQR_CODE_LOCK, `RSQR_CODE_CMD, `RSQR_CODE_AMPS, `RSQR_CODE_TAPE, `RSQR_CODE_MARK};
   logic [15:0]  idxs [7] = '{`RSQR_IDX_FLAGS, `RSQR_IDX_HALL, `RSQR_IDX_RADIO, `RSQR_IDX_CMD,
                              `RSQR_IDX_AMPS, `RSQR_IDX_TAPE, `RSQR_IDX_MARK};
   logic [7:0]   icode [7] = '{`RSQR_CODE_FLAGS, `RSQR_CODE_HALL, `RSQR_CODE_RADIO, `RSQR_CODE_CMD,
                               `RSQR_CODE_AMPS, `RSQR_CODE_TAPE, `RSQR_CODE_MARK};

   always #2 hclk = ~hclk;

   rsqr_host host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
                   .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

   rsqr_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
                 .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
                 .hresp(hresp), .serial_mode(st[0]), .pulse_mode(st[1]), .analog_mode(st[2]), .radio_mode(st[3]),
                 .power_off(st[4]), .stall_det(st[5]), .at_limit(st[6]), .script_run(st[7]),
                 .tuning_mode(st[8]), .hall_input_a(hall_a), .hall_input_b(hall_b), .hall_input_c(hall_c),
                 .node_alive(node), .radio_raw(raw), .radio_link_ok(link), .config_locked(lock),
                 .applied_cmd(cmd), .vec_current(amps), .multi_sensor(multi), .tape_det(det), .tape_mark(mark));

   task automatic stop_test();
      if (failures == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk_word(input string n, input logic [63:0] e, input logic [63:0] g);
      total_checks++;
      if (g !== e)
      begin
         failures++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic chk_flag(input string n, input logic e, input logic g);
      total_checks++;
      if (g !== e)
      begin
         failures++;
         $display("unexpected %s expected %b seen %b", n, e, g);
      end
   endtask

   // Radio layout moves the power, stall and limit flags up one place
   function automatic logic [15:0] flags_exp();
      if (ctrl[1])
         return {7'h0, st[8:7], st[6:4], st[3], st[2:0]};
      return {7'h0, st[8:7], 1'b0, st[6:4], st[2:0]};
   endfunction

   function automatic logic [2:0] hcode(input int m);
      return {hall_c[m], hall_b[m], hall_a[m]};
   endfunction

   function automatic logic hvalid(input logic [2:0] c);
      return ctrl[0] ? (c != 3'h0 && c != 3'h7) : (c != 3'h2 && c != 3'h5);
   endfunction

   // Returns one when the query must be rejected
   function automatic logic model(input logic [7:0] c, input int a, output logic [63:0] v, output logic [63:0] m);
      model = 1'b0;
      v = 64'h0;
      m = '1;
      case (c)
         `RSQR_CODE_FLAGS: v[15:0] = flags_exp();
         `RSQR_CODE_HALL:
            if (a == 0) begin v[2:0] = hcode(0); v[10:8] = hcode(1); end
            else if (a <= 2) v[2:0] = hcode(a - 1);
            else model = 1'b1;
         `RSQR_CODE_NODE: if (a >= 1 && a <= 127) v[0] = node[a]; else model = 1'b1;
         `RSQR_CODE_RADIO: if (a >= 1 && a <= 6) v[10:0] = link ? raw[(a - 1) * 11 +: 11] : 11'h0; else model = 1'b1;
         `RSQR_CODE_LOCK: v[0] = lock;
         `RSQR_CODE_CMD:
            if (a == 0) v = cmd;
            else if (a <= 2) begin v[31:0] = cmd[(a - 1) * 32 +: 32]; m = 64'hFFFFFFFF; end
            else model = 1'b1;
         `RSQR_CODE_AMPS: if (a >= 1 && a <= 4) begin v[15:0] = amps[(a - 1) * 16 +: 16]; m = 64'hFFFF; end
            else model = 1'b1;
         `RSQR_CODE_TAPE:
            if (multi && a == 0) begin v[0] = det[0]; v[8] = det[1]; end
            else if (multi && a <= 2) v[0] = det[a - 1];
            else if (!multi && a <= 1) v[0] = |det;
            else model = 1'b1;
         `RSQR_CODE_MARK:
            if (multi && a >= 1 && a <= 4) v[0] = mark[a - 1];
            else if (!multi && a >= 1 && a <= 2) v[0] = mark[a - 1] | mark[a + 1];
            else model = 1'b1;
         default: model = 1'b1;
      endcase
   endfunction

   // One query: write, poll done, read both reply words, compare with model
   task automatic query(input logic [7:0] c, input int a, input logic [15:0] ix, input logic [7:0] mc);
      logic [31:0] s, lo, hi;
      logic [63:0] v, m;
      logic        rj;
      int          n;
      host.xfer(`RSQR_OFF_QUERY, 1'b1, {ix, a[7:0], c}, s);
      n = 0;
      do begin host.xfer(`RSQR_OFF_RSTAT, 1'b0, 32'h0, s); n++; end while (s[0] !== 1'b1 && n < 20);
      host.xfer(`RSQR_OFF_REPLY, 1'b0, 32'h0, lo);
      host.xfer(`RSQR_OFF_REPLYHI, 1'b0, 32'h0, hi);
      rj = model(mc, a, v, m);
      chk_flag("done", 1'b1, s[0]);
      chk_flag("rejected", rj, s[1]);
      chk_flag("lock bit", lock, s[2]);
      chk_flag("hresp", 1'b0, hresp);
      chk_word("echo", {40'h0, ix, c}, {40'h0, s[31:16], s[15:8]});
      chk_word("reply", v & m, {hi, lo} & m);
   endtask

   // Watchdog sized well above the expected run of about 9200 cycles
   initial
   begin
      repeat (60000) @(posedge hclk);
      failures++;
      stop_test();
   end

   initial
   begin
      hresetn = 1'b0;
      {st, hall_a, hall_b, hall_c, det, mark, ctrl, link, lock, multi} = '0;
      {node, raw, cmd, amps} = '0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (2) @(posedge hclk);
      host.xfer(32'h40, 1'b0, 32'h0, d);
      chk_word("unmapped", 64'h0, {32'h0, d});
      for (int r = 0; r < 12; r++)
      begin
         // New random live state each round; lock, link and mode walk all combinations
         rnd = $random(seed);
         st <= rnd[8:0];
         // First round leaves every hall pin high, as an open input would
         {hall_a, hall_b, hall_c} <= (r == 0) ? 6'h3F : rnd[14:9];
         det <= rnd[16:15];
         mark <= rnd[20:17];
         ctrl <= 2'(r / 3);
         link <= r[0];
         lock <= r[1];
         multi <= r[2];
         node <= {$random(seed), $random(seed), $random(seed), $random(seed)};
         cmd <= {$random(seed), $random(seed)};
         amps <= {$random(seed), $random(seed)};
         for (int k = 0; k < 6; k++)
         begin
            rnd = $unsigned($random(seed)) % 1025;
            raw[k * 11 +: 11] <= rnd[10:0];
         end
         @(posedge hclk);
         host.xfer(`RSQR_OFF_CTRL, 1'b1, {30'h0, ctrl}, d);
         host.xfer(`RSQR_OFF_CTRL, 1'b0, 32'h0, d);
         chk_word("ctrl", lock ? 64'h0 : {62'h0, ctrl}, {32'h0, d});
         host.xfer(`RSQR_OFF_FLAGS, 1'b0, 32'h0, d);
         chk_word("flags", {48'h0, flags_exp()}, {32'h0, d});
         host.xfer(`RSQR_OFF_HALL, 1'b0, 32'h0, d);
         chk_word("hall", {54'h0, hvalid(hcode(1)), hvalid(hcode(0)), 1'b0, hcode(1), 1'b0, hcode(0)},
                  {32'h0, d});
         // Every code but FLAGS and LOCK with arguments from none to 7, beyond range for all but NODE, plus a random one; those two with none only
         for (int i = 0; i < 9; i++)
            for (int a = 0; a < 9; a++)
               if (a == 0 || (i != 0 && i != 4))
                  query(codes[i], (a == 8) ? ($unsigned($random(seed)) % 256) : a, 16'h0, codes[i]);
         query(`RSQR_CODE_NODE, 127, 16'h0, `RSQR_CODE_NODE);
         query(`RSQR_CODE_NODE, 128, 16'h0, `RSQR_CODE_NODE);
         for (int i = 0; i < 7; i++)
            query(8'h00, (i == 0) ? 0 : 1, idxs[i], icode[i]);
         query(8'hFF, 1, 16'h0, 8'hFF);
         query(8'h00, 0, 16'h0, 8'h00);
      end
      stop_test();
   end
endmodule // tb_runtime_status_query_responder
